// file: rtl/asmc_pkg.sv
// constants and types shared by the converter control block
`default_nettype none

package asmc_pkg;

  // result width and frame figures
  localparam int unsigned RES_W          = 10;        // result word width
  localparam int unsigned SAMPLE_HALVES  = 3;         // sample phase in half serial cycles
  localparam int unsigned CONV_CYCLES    = 10;        // conversion serial cycles
  localparam int unsigned FRAME_PERIODS  = 15;        // serial periods in a full frame
  localparam int unsigned CNT_W          = 4;         // width of the serial cycle counter

  // mux configuration bit values
  localparam logic        MODE_DIFF      = 1'b0;      // input_mode_bit: differential
  localparam logic        MODE_SINGLE    = 1'b1;      // input_mode_bit: single ended
  localparam logic [1:0]  SEL_A          = 2'h0;      // positive_input/negative_input: input_a
  localparam logic [1:0]  SEL_B          = 2'h1;      // positive_input/negative_input: input_b
  localparam logic [1:0]  SEL_GND        = 2'h2;      // negative_input select: ground

  // reset values
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;  // result register after reset
  localparam logic [CNT_W-1:0] CNT_RST    = 4'h0;     // counter after reset
  localparam logic [2:0]       SYNC_RST   = 3'h7;     // synchroniser chain idle value (high)
  localparam logic [2:0]       SYNC_LOW   = 3'h0;     // synchroniser chain idle value (low)

  // sequencer states
  typedef enum logic [2:0] {
    ASMC_IDLE   = 3'b000,   // deselected, powered down
    ASMC_WAIT   = 3'b001,   // selected, waiting for the start marker
    ASMC_MODE   = 3'b010,   // take the mode bit
    ASMC_POL    = 3'b011,   // take the polarity bit
    ASMC_SAMPLE = 3'b100,   // sample and hold
    ASMC_CONV   = 3'b101,   // successive approximation, one bit per cycle
    ASMC_DONE   = 3'b110    // frame over, wait for deselect
  } asmc_state_t;

endpackage

`default_nettype wire

// file: rtl/asmc_sync.sv
// three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ns
`default_nettype none

module asmc_sync (
  input  wire logic clk_in,     // sampling clock
  input  wire logic rst_in,     // asynchronous reset, active high
  input  wire logic pin_in,     // raw pin from another domain
  input  wire logic rst_val_in, // inverts the level so reset reads the pin's idle state
  output var  logic level_out   // filtered level
);

  logic [2:0] chain_r;    // stage 0 is the metastability catcher
  logic [2:0] chain_nxt;  // next chain value
  logic       level_r;    // agreed level
  logic       level_nxt;  // next agreed level

  //////////////////////////////////////////////////////////////////////////////
  // next values: shift in, update level only when stages one and two agree
  always_comb begin
    chain_nxt = {chain_r[1:0], pin_in};
    level_nxt = level_r;
    if (chain_r[1] == chain_r[2]) begin
      level_nxt = chain_r[2];
    end
  end

  // registers; reset takes a constant only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chain_r <= asmc_pkg::SYNC_LOW;
      level_r <= 1'b0;
    end else begin
      chain_r <= chain_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r ^ rst_val_in;

endmodule

`default_nettype wire

// file: rtl/asmc_top.sv
// serial control and mux sequencing for a two-channel sampling converter
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [RQ1] sample phase lasts one and half cycles
// [RQ2] conversion takes ten serial cycles
// [RQ3] each conversion yields a ten-bit result
// [RQ4] deselect forces shutdown until reselected
// [RQ5] result leaves most significant bit first
// [RQ6] latch mode bit then polarity bit
// [RQ7] mode zero: differential, polarity picks order
// [RQ8] mode one: single channel against ground
// [RQ9] leading zeros ignored; first one starts
// [RQ10] host raises select between conversions
// [RQ11] data output released while deselected
// [RQ12] frame spans fifteen serial periods
// [RQ13] sample on rising, change after falling
module asmc_top (
  input  wire logic       ref_clk_in,      // 25 MHz block clock
  input  wire logic       sys_rst_in,      // asynchronous reset, active high
  input  wire logic       sclk_in,         // serial clock from host
  input  wire logic       cs_n_in,         // chip select, active low
  input  wire logic       din_in,          // serial data in
  input  wire logic       cmp_in,          // comparator: 1 when dac below input
  output var  logic       dout_out,        // serial data out value
  output var  logic       dout_oe_out,     // serial data out drive enable
  output var  logic       shutdown_out,    // analog power down
  output var  logic       track_out,       // sample switch closed
  output var  logic [1:0] pos_sel_out,     // positive_input mux select
  output var  logic [1:0] neg_sel_out,     // negative_input mux select
  output var  logic [9:0] dac_code_out,    // trial code for the dac
  output var  logic [9:0] result_out,      // last complete result
  output var  logic       result_vld_out   // one-cycle pulse on new result
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sclk_s;   // filtered serial clock
  logic csn_s;    // filtered chip select
  logic din_s;    // filtered data in
  logic sclk_d_r; // previous filtered clock

  asmc_sync u_sync_clk (
    .clk_in     (ref_clk_in),
    .rst_in     (sys_rst_in),
    .pin_in     (sclk_in),
    .rst_val_in (1'b0),
    .level_out  (sclk_s)
  );
  // chip select idles high: invert through the filter so reset reads deselected
  asmc_sync u_sync_cs (
    .clk_in     (ref_clk_in),
    .rst_in     (sys_rst_in),
    .pin_in     (~cs_n_in),
    .rst_val_in (1'b1),
    .level_out  (csn_s)
  );
  asmc_sync u_sync_din (
    .clk_in     (ref_clk_in),
    .rst_in     (sys_rst_in),
    .pin_in     (din_in),
    .rst_val_in (1'b0),
    .level_out  (din_s)
  );

  logic rise; // rising serial edge seen
  logic fall; // falling serial edge seen
  // [RQ13] edge detection
  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // mux decode, used for both select outputs
  function automatic logic [3:0] mux_sel(input logic mode, input logic pol);
    logic [1:0] p;
    logic [1:0] n;
    p = pol ? asmc_pkg::SEL_B : asmc_pkg::SEL_A;
    if (mode == asmc_pkg::MODE_DIFF) begin
      n = pol ? asmc_pkg::SEL_A : asmc_pkg::SEL_B;
    end else begin
      n = asmc_pkg::SEL_GND;
    end
    return {p, n};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // sequencer state
  asmc_pkg::asmc_state_t st_r, st_nxt;            // sequencer state
  logic [3:0] cnt_r, cnt_nxt;                     // half or whole cycle counter
  logic       mode_r, mode_nxt;                   // latched input_mode_bit
  logic       pol_r, pol_nxt;                     // latched polarity bit
  logic [9:0] sar_r, sar_nxt;                     // approximation register
  logic [9:0] res_r, res_nxt;                     // result output register
  logic       vld_r, vld_nxt;                     // result pulse
  logic       dout_r, dout_nxt;                   // output bit
  logic       oe_r, oe_nxt;                       // output enable
  logic       pend_r, pend_nxt;                   // comparator bit awaiting a falling edge
  logic [3:0] sel_r, sel_nxt;                     // mux selects
  // next-state logic
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    mode_nxt = mode_r;
    pol_nxt  = pol_r;
    sar_nxt  = sar_r;
    res_nxt  = res_r;
    vld_nxt  = 1'b0;
    dout_nxt = dout_r;
    oe_nxt   = oe_r;
    pend_nxt = pend_r;
    sel_nxt  = mux_sel(mode_r, pol_r);
    if (csn_s) begin
      // [RQ4] deselect aborts and powers down
      st_nxt   = asmc_pkg::ASMC_IDLE;
      // [RQ11] release data line
      oe_nxt   = 1'b0;
      dout_nxt = 1'b0;
      pend_nxt = 1'b0;
    end else begin
      case (st_r)
        asmc_pkg::ASMC_IDLE: begin
          // [RQ10] new frame only after a deselect
          st_nxt = asmc_pkg::ASMC_WAIT;
        end
        asmc_pkg::ASMC_WAIT: begin
          // [RQ9] first one is the start marker
          if (rise && din_s) begin
            st_nxt = asmc_pkg::ASMC_MODE;
          end
        end
        asmc_pkg::ASMC_MODE: begin
          // [RQ6] take mode bit
          if (rise) begin
            mode_nxt = din_s;
            st_nxt   = asmc_pkg::ASMC_POL;
          end
        end
        asmc_pkg::ASMC_POL: begin
          // [RQ6] take polarity bit, then sample
          if (rise) begin
            pol_nxt = din_s;
            cnt_nxt = asmc_pkg::CNT_RST;
            st_nxt  = asmc_pkg::ASMC_SAMPLE;
          end
        end
        asmc_pkg::ASMC_SAMPLE: begin
          // [RQ1] hold for three half cycles, ending on a falling edge
          if (rise || fall) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(asmc_pkg::SAMPLE_HALVES - 1)) begin
              cnt_nxt  = asmc_pkg::CNT_RST;
              sar_nxt  = 10'h200;
              oe_nxt   = 1'b1;   // null bit leads the result
              dout_nxt = 1'b0;
              st_nxt   = asmc_pkg::ASMC_CONV;
            end
          end
        end
        asmc_pkg::ASMC_CONV: begin
          // [RQ2] decide one bit per rising edge
          if (rise) begin
            sar_nxt[4'(asmc_pkg::RES_W - 1) - cnt_r] = cmp_in;
            if (cnt_r != 4'(asmc_pkg::CONV_CYCLES - 1)) begin
              sar_nxt[4'(asmc_pkg::RES_W - 2) - cnt_r] = 1'b1;
            end
            pend_nxt = cmp_in;
            cnt_nxt  = cnt_r + 4'h1;
          end
          // [RQ5] shift each decided bit out, msb first, after the fall
          if (fall && cnt_r != asmc_pkg::CNT_RST) begin
            dout_nxt = pend_r;
            if (cnt_r == 4'(asmc_pkg::CONV_CYCLES)) begin
              // [RQ3] ten-bit word complete
              res_nxt = sar_r;
              vld_nxt = 1'b1;
              st_nxt  = asmc_pkg::ASMC_DONE;
            end
          end
        end
        asmc_pkg::ASMC_DONE: begin
          // [RQ12] frame over; lsb stands until deselect
          st_nxt = asmc_pkg::ASMC_DONE;
        end
        default: begin
          st_nxt = asmc_pkg::ASMC_IDLE;
        end
      endcase
    end
  end
  // sequencer registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r     <= asmc_pkg::ASMC_IDLE;
      cnt_r    <= asmc_pkg::CNT_RST;
      mode_r   <= asmc_pkg::MODE_DIFF;
      pol_r    <= 1'b0;
      sar_r    <= asmc_pkg::RESULT_RST;
      res_r    <= asmc_pkg::RESULT_RST;
      vld_r    <= 1'b0;
      dout_r   <= 1'b0;
      oe_r     <= 1'b0;
      pend_r   <= 1'b0;
      sel_r    <= 4'h1;
      sclk_d_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      mode_r   <= mode_nxt;
      pol_r    <= pol_nxt;
      sar_r    <= sar_nxt;
      res_r    <= res_nxt;
      vld_r    <= vld_nxt;
      dout_r   <= dout_nxt;
      oe_r     <= oe_nxt;
      pend_r   <= pend_nxt;
      sel_r    <= sel_nxt;
      sclk_d_r <= sclk_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs: all from flip-flops
  logic shut_r;  // power down register
  logic trk_r;   // track register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shut_r <= 1'b1;
      trk_r  <= 1'b0;
    end else begin
      // [RQ4] powered only while a frame is selected
      shut_r <= (st_nxt == asmc_pkg::ASMC_IDLE);
      trk_r  <= (st_nxt == asmc_pkg::ASMC_SAMPLE);
    end
  end
  // [RQ7] [RQ8] mux selects from latched bits
  assign pos_sel_out    = sel_r[3:2];
  assign neg_sel_out    = sel_r[1:0];
  assign dout_out       = dout_r;
  assign dout_oe_out    = oe_r;
  assign shutdown_out   = shut_r;
  assign track_out      = trk_r;
  assign dac_code_out   = sar_r;
  assign result_out     = res_r;
  assign result_vld_out = vld_r;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_hiz_desel;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      csn_s |=> !dout_oe_out;
  endproperty
  a_hiz_desel: assert property (p_hiz_desel) else $error("dout driven while deselected"); // [RQ11]
  property p_shut_desel;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      csn_s |=> shutdown_out;
  endproperty
  a_shut_desel: assert property (p_shut_desel) else $error("not shut down when deselected"); // [RQ4]
  property p_conv_len;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_r == asmc_pkg::ASMC_CONV && rise && !csn_s) |=> (cnt_r <= 4'(asmc_pkg::CONV_CYCLES));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion ran past ten bits"); // [RQ2]
  property p_sample_end;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_r == asmc_pkg::ASMC_SAMPLE && st_nxt == asmc_pkg::ASMC_CONV) |-> fall;
  endproperty
  a_sample_end: assert property (p_sample_end) else $error("sample phase not ended on fall"); // [RQ1]
  property p_start;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_r == asmc_pkg::ASMC_WAIT && rise && !din_s) |=> st_r != asmc_pkg::ASMC_MODE;
  endproperty
  a_start: assert property (p_start) else $error("zero taken as start marker"); // [RQ9]
  property p_sel;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (mode_r == asmc_pkg::MODE_SINGLE) && $stable(mode_r) |=> neg_sel_out == asmc_pkg::SEL_GND;
  endproperty
  a_sel: assert property (p_sel) else $error("single ended not ground referenced"); // [RQ8]
  property p_diff;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (mode_r == asmc_pkg::MODE_DIFF) && $stable({mode_r, pol_r})
        |=> pos_sel_out != neg_sel_out && neg_sel_out != asmc_pkg::SEL_GND;
  endproperty
  a_diff: assert property (p_diff) else $error("differential selects wrong"); // [RQ7]
  property p_vld;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      result_vld_out |-> result_out == dac_code_out && dout_out == dac_code_out[0];
  endproperty
  a_vld: assert property (p_vld) else $error("result not matching lsb out"); // [RQ3]
  property p_edges;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      $changed(dout_out) && !csn_s |-> $past(fall) || $past(st_r) == asmc_pkg::ASMC_SAMPLE;
  endproperty
  a_edges: assert property (p_edges) else $error("dout changed off a falling edge"); // [RQ13]

endmodule

`default_nettype wire

// file: testbench/asmc_host_model.sv
// serial master model that frames conversions on the link pins
`timescale 1ns/1ns
`default_nettype none

module asmc_host_model (
  input  wire logic clk_in,     // block clock, pins move on its falling edge
  input  wire logic dout_in,    // device data value
  input  wire logic dout_oe_in, // device drive enable
  output var  logic sclk_out,   // serial clock, still outside frames
  output var  logic cs_n_out,   // chip select, active low
  output var  logic din_out     // serial data to device
);
  logic last_r = 1'b0; // last value the device drove
  logic line;          // resolved data wire
  ////////////////////////////////////////////////////////////////////////
  // a released wire shows the inverse of its last driven value
  always @(posedge clk_in) if (dout_oe_in) last_r <= dout_in;
  assign line = dout_oe_in ? dout_in : ~last_r;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // half of a 320 ns serial period
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // one serial period: data set while low, line read before the fall
  // drive on fall
  task automatic period(input logic d, output logic s, output logic o);
    din_out = d;
    half();
    sclk_out = 1'b1;
    half();
    s = line;
    o = dout_oe_in;
    sclk_out = 1'b0;
  endtask
  // one frame; stop below 15 aborts it by deselecting early
  task automatic frame(input logic m, input logic p, input int zeros, input int stop,
                       output logic [10:0] word, output logic oe_bad);
    logic s;
    logic o;
    word = 11'h000;
    oe_bad = 1'b0;
    cs_n_out = 1'b0;
    half();
    for (int i = 0; i < zeros; i++) period(1'b0, s, o);
    for (int k = 1; k <= 15; k++) begin
      period((k == 1) ? 1'b1 : (k == 2) ? m : (k == 3) ? p : 1'($urandom), s, o);
      if (k <= 4 && o !== 1'b0) oe_bad = 1'b1;
      if (k >= 5) begin
        word = {word[9:0], s};
        if (o !== 1'b1) oe_bad = 1'b1;
      end
      if (k == stop) break;
    end
    half();
    cs_n_out = 1'b1;
    din_out  = 1'b0;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_asmc_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none

module tb_asmc_top;
  logic       clk, rst, sclk, cs_n, din, cmp;   // design inputs
  logic       dout, oe, shd, trk, vld;          // design flags
  logic [1:0] psel, nsel;                       // mux selects
  logic [9:0] dac, res, va, vb;                 // codes and channel levels
  logic [10:0] word;                            // null bit plus result
  logic       oe_bad;                           // enable seen out of place
  int         error_cnt, n_checks, trk_cnt, vld_cnt, lo_cnt;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  asmc_top u_asmc_top (.ref_clk_in(clk), .sys_rst_in(rst), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .cmp_in(cmp), .dout_out(dout), .dout_oe_out(oe), .shutdown_out(shd),
    .track_out(trk), .pos_sel_out(psel), .neg_sel_out(nsel), .dac_code_out(dac),
    .result_out(res), .result_vld_out(vld));
  asmc_host_model u_asmc_host_model (.clk_in(clk), .dout_in(dout), .dout_oe_in(oe),
    .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));
  ////////////////////////////////////////////////////////////////////////
  // level on a mux select, ground reads zero
  function automatic int lvl(input logic [1:0] s);
    return (s === asmc_pkg::SEL_A) ? int'(va) : (s === asmc_pkg::SEL_B) ? int'(vb) : 0;
  endfunction
  // comparator: one while the trial code lies below the input
  always @(negedge clk) cmp <= (int'(dac) < lvl(psel) - lvl(nsel));
  // result a binary search must reach for the chosen mux setting
  function automatic logic [9:0] exp_code(input logic m, input logic p);
    int v;
    logic [9:0] c;
    v = m ? (p ? int'(vb) : int'(va)) : (p ? int'(vb) - int'(va) : int'(va) - int'(vb));
    c = 10'h000;
    for (int k = 9; k >= 0; k--) if (int'(c | (10'h001 << k)) < v) c = c | (10'h001 << k);
    return c;
  endfunction
  // cycle counters for sampling, new results and power-up
  always @(posedge clk) begin
    if (trk === 1'b1) trk_cnt++;
    if (vld === 1'b1) vld_cnt++;
    if (cs_n === 1'b0 && shd === 1'b0) lo_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one frame, complete or aborted, with its checks
  task automatic conv(input logic m, input logic p, input int zeros, input int stop);
    logic [9:0] prev;
    int         t0;
    int         v0;
    int         l0;
    // counters run free; take a snapshot so only this frame is judged
    prev = res;
    t0 = trk_cnt;
    v0 = vld_cnt;
    l0 = lo_cnt;
    u_asmc_host_model.frame(m, p, zeros, stop, word, oe_bad);
    chk("shutdown", 1, shd);
    chk("oe idle", 0, oe);
    if (stop == 15) begin
      chk("serial word", {1'b0, exp_code(m, p)}, word);
      chk("result", exp_code(m, p), res);
      chk("vld pulses", 1, vld_cnt - v0);
      chk("track 1.5", 1, (trk_cnt - t0 >= 11 && trk_cnt - t0 <= 13));
      chk("oe frame", 0, oe_bad);
      chk("powered", 1, lo_cnt - l0 > 100);
      chk("pos select", p ? asmc_pkg::SEL_B : asmc_pkg::SEL_A, psel);
      chk("neg select", m ? asmc_pkg::SEL_GND : (p ? asmc_pkg::SEL_A : asmc_pkg::SEL_B), nsel);
    end else begin
      chk("abort vld", 0, vld_cnt - v0);
      chk("abort res", prev, res);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence: reset, every mux setting, aborts, random frames
  initial begin
    rst = 1'b1;
    va = 10'h000;
    vb = 10'h000;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(32'hA649A177));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk("rst shutdown", 1, shd);
    chk("rst oe", 0, oe);
    chk("rst result", asmc_pkg::RESULT_RST, res);
    // all four mux settings, rail values first
    for (int i = 0; i < 4; i++) begin
      va = (i == 0) ? 10'h3FF : 10'($urandom);
      vb = (i == 0) ? 10'h000 : 10'($urandom);
      conv(i[1], i[0], i, 15);
    end
    va = 10'h155;
    conv(1'b0, 1'b0, 0, 8);
    conv(1'b1, 1'b1, 2, 2);
    for (int i = 0; i < 12; i++) begin
      va = 10'($urandom);
      vb = 10'($urandom);
      conv(1'($urandom), 1'($urandom), $urandom % 4, 15);
    end
    final_report();
  end
  // watchdog on a hung run
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
